/* File: design/sac_pkg.sv */
// package: addresses, field layout, reset values and codes of the converter
package sac_pkg;
   // register addresses on the special-function register port
   localparam logic [7:0] SAC_ADDR_PAIR = 8'hBA;  // input_pair_config
   localparam logic [7:0] SAC_ADDR_CHAN = 8'hBB;  // channel_select
   localparam logic [7:0] SAC_ADDR_CFG  = 8'hBC;  // converter_config
   localparam logic [7:0] SAC_ADDR_CTRL = 8'hE8;  // converter_control
   // values after reset
   localparam logic [7:0] SAC_PAIR_RST  = 8'h00;
   localparam logic [7:0] SAC_CHAN_RST  = 8'h00;
   localparam logic [7:0] SAC_CFG_RST   = 8'hF8;
   localparam logic [7:0] SAC_CTRL_RST  = 8'h00;
   // field positions
   localparam int SAC_EN_BIT    = 7;  // conv_enable
   localparam int SAC_LP_BIT    = 6;  // low_power_track_sel
   localparam int SAC_DONE_BIT  = 5;  // conv_done_flag
   localparam int SAC_BUSY_BIT  = 4;  // conv_busy
   localparam int SAC_MODE_LSB  = 1;  // start_mode_sel
   localparam int SAC_WIN_BIT   = 0;  // window_match_flag
   localparam int SAC_DIV_LSB   = 3;  // sar_clk_divider
   localparam int SAC_GAIN_LSB  = 0;  // amp_gain_sel
   localparam int SAC_DIV_W     = 5;
   localparam int SAC_MODE_W    = 3;
   localparam int SAC_CHAN_W    = 3;
   localparam int SAC_PAIR_W    = 4;
   // start-mode codes
   localparam logic [2:0] SAC_MODE_SW  = 3'h0;
   localparam logic [2:0] SAC_MODE_T3  = 3'h1;
   localparam logic [2:0] SAC_MODE_EXT = 3'h2;
   localparam logic [2:0] SAC_MODE_T2  = 3'h3;
   // cycle counts, in conversion clocks, and the system clock period
   localparam logic [3:0] SAC_LP_TRACK_CLKS = 4'h3;
   localparam int         SAC_CONV_CLKS     = 8;
   localparam int         SAC_CLK_PERIOD_NS = 50;
   // sequencer states
   typedef enum logic [2:0] {
      S_IDLE  = 3'b001,
      S_TRACK = 3'b010,
      S_CONV  = 3'b100
   } sac_state_t;
   // true when the selected channel sits in a pair set to differential
   function automatic logic sac_is_diff(input logic [3:0] pair,
                                        input logic [2:0] ch);
      sac_is_diff = pair[ch[2:1]];
   endfunction
   // negative input: partner pin of the pair, or ground code zero
   function automatic logic [2:0] sac_neg(input logic [3:0] pair,
                                          input logic [2:0] ch);
      sac_neg = sac_is_diff(pair, ch) ? (ch ^ 3'h1) : 3'h0;
   endfunction
endpackage

/* File: design/sac_res_if.sv */
// interface: raw result, limits and formatted word between sequencer and window
`timescale 1ns/1ps
`default_nettype none
interface sac_res_if;
   logic [7:0] raw;    // code from the analog core
   logic       diff;   // selected channel is differential
   logic       load;   // end-of-conversion pulse
   logic [7:0] gt;     // greater-than limit
   logic [7:0] lt;     // less-than limit
   logic [7:0] word;   // formatted data word, registered
   logic       match;  // window match of the current raw code
   modport ctrl (output raw, diff, load, gt, lt, input word, match);
   modport win  (input raw, diff, load, gt, lt, output word, match);
endinterface
`default_nettype wire

/* File: design/sac_sar_clkdiv.sv */
// module: conversion clock divider, one tick every divider+1 system clocks
`timescale 1ns/1ps
`default_nettype none
module sac_sar_clkdiv (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // control
   input  wire logic       run_i,
   input  wire logic [4:0] div_i,
   // outputs
   output logic            tick_o,
   output logic            sar_clk_o
);
   logic [4:0] cnt_reg;  // position inside one conversion clock period

   // restart on every start so the first tick lands a full period later
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg <= 5'h00;
      end else if (!run_i || cnt_reg == div_i) begin
         cnt_reg <= 5'h00;
      end else begin
         cnt_reg <= cnt_reg + 5'h01;
      end
   end

   // tick is combinational so the sequencer sees it in the same cycle
   assign tick_o = run_i && (cnt_reg == div_i);  // [RULE14]

   // clock level for the core: high over the first half period
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sar_clk_o <= 1'b0;
      end else begin
         sar_clk_o <= run_i && (cnt_reg <= (div_i >> 1));
      end
   end
endmodule
`default_nettype wire

/* File: design/sac_window.sv */
// module: result formatting, data word register and window comparison
`timescale 1ns/1ps
`default_nettype none
module sac_window (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // result path
   sac_res_if.win    res
);
   import sac_pkg::*;

   logic [7:0] fmt;  // raw code in its delivered format

   // compare a against b, signed when the channel is differential
   function automatic logic above(input logic [7:0] a, input logic [7:0] b,
                                  input logic sgn);
      above = sgn ? ($signed(a) > $signed(b)) : (a > b);
   endfunction

   // core code is offset binary; flipping the top bit gives two's complement
   assign fmt = res.diff ? (res.raw ^ 8'h80) : res.raw;  // [RULE18]

   // limits in order select in-range, otherwise out-of-range detection
   always_comb begin
      if (above(res.lt, res.gt, res.diff)) begin
         res.match = above(fmt, res.gt, res.diff)
                  && above(res.lt, fmt, res.diff);  // [RULE21]
      end else begin
         res.match = above(fmt, res.gt, res.diff)
                  || above(res.lt, fmt, res.diff);  // [RULE21]
      end
   end

   // data word takes the result at the end of each conversion
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         res.word <= 8'h00;
      end else if (res.load) begin
         res.word <= fmt;  // [RULE20]
      end
   end

   a_diff_format: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      res.load && res.diff |=> res.word == ($past(res.raw) ^ 8'h80))
      else $error("differential word not in two's complement"); // [RULE18]
endmodule
`default_nettype wire

/* File: design/sac_top.sv */
// module: converter control, start selection, sequencer and registers
//
// Function
// RULE1: enable low holds converter shut down
// RULE2: normal mode tracks except while converting
// RULE3: done flag sets when busy falls
// RULE4: software alone clears the done flag
// RULE5: busy reads one during conversion
// RULE6: busy write starts only in software mode
// RULE7: timer overflows start in their modes
// RULE8: external rising edge starts conversion
// RULE9: companion busy write starts in 1xx
// RULE10: low-power triggers track three clocks first
// RULE11: low-power external mode tracks while low
// RULE12: own start pin wins over shared
// RULE13: window flag sets on match, sticky
// RULE14: conversion clock is system over divider+1
// RULE15: gain field drives amplifier gain
// RULE16: pair bits make inputs differential
// RULE17: channel code picks pin and polarity
// RULE18: differential results in two's complement
// RULE19: unused bits read zero, writes ignored
// RULE20: busy fall raises interrupt, loads word
// RULE21: window compares result against both limits
// RULE22: triggers during a conversion are ignored
`timescale 1ns/1ps
`default_nettype none
module sac_top #(
   parameter int CONV_CLKS = sac_pkg::SAC_CONV_CLKS  // clocks per conversion
) (
   // clock and reset
   input  wire logic       CLOCK_I,
   input  wire logic       RST_N_I,
   // special-function register port
   input  wire logic [7:0] SFR_ADDR_I,
   input  wire logic [7:0] SFR_WDATA_I,
   input  wire logic       SFR_WR_I,
   input  wire logic       SFR_RD_I,
   output logic      [7:0] SFR_RDATA_O,
   // start sources
   input  wire logic       T3_OVF_I,
   input  wire logic       T2_OVF_I,
   input  wire logic       COMPANION_BUSY_WR_I,
   input  wire logic       EXT_START_OWN_I,
   input  wire logic       EXT_START_SHARED_I,
   input  wire logic       OWN_PIN_EN_I,
   input  wire logic       SHARED_PIN_EN_I,
   // window limits and core result
   input  wire logic [7:0] GT_LIMIT_I,
   input  wire logic [7:0] LT_LIMIT_I,
   input  wire logic [7:0] CORE_RESULT_I,
   // analog core control
   output logic            CONV_ACTIVE_O,
   output logic            TRACK_O,
   output logic            CONVERT_O,
   output logic            SAR_CLK_O,
   output logic      [1:0] AMP_GAIN_O,
   output logic      [2:0] MUX_POS_O,
   output logic      [2:0] MUX_NEG_O,
   output logic            MUX_DIFF_O,
   // result and event
   output logic      [7:0] DATA_WORD_O,
   output logic            CONV_IRQ_O
);
   import sac_pkg::*;

   localparam logic [3:0] CONV_LAST = 4'(CONV_CLKS - 1);  // last tick index
   localparam logic [3:0] TRK_LAST  = SAC_LP_TRACK_CLKS - 4'h1;

   sac_res_if res ();  // result path to the window block

   logic [3:0] pair_reg;   // pair differential bits
   logic [2:0] chan_reg;   // channel_code
   logic [4:0] div_reg;    // sar_clk_divider
   logic [1:0] gain_reg;   // amp_gain_sel
   logic       en_reg;     // conv_enable
   logic       lp_reg;     // low_power_track_sel
   logic [2:0] mode_reg;   // start_mode_sel
   logic       done_reg;   // conv_done_flag
   logic       win_reg;    // window_match_flag
   logic [3:0] cnt_reg;    // conversion clocks spent in this state
   logic       own_s1, own_s2, sh_s1, sh_s2;  // pin synchronisers
   logic       ext_prev_reg;                  // last external level
   logic       ext_level, ext_rise;
   logic       wr_pair, wr_chan, wr_cfg, wr_ctrl;
   logic       sw_go, int_go, ext_go, conv_end, sar_tick, busy;
   sac_state_t state_reg, state_next;

   // address decode of the register port
   assign wr_pair = SFR_WR_I && (SFR_ADDR_I == SAC_ADDR_PAIR);
   assign wr_chan = SFR_WR_I && (SFR_ADDR_I == SAC_ADDR_CHAN);
   assign wr_cfg  = SFR_WR_I && (SFR_ADDR_I == SAC_ADDR_CFG);
   assign wr_ctrl = SFR_WR_I && (SFR_ADDR_I == SAC_ADDR_CTRL);

   // configuration registers; only implemented bits are stored
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pair_reg <= SAC_PAIR_RST[SAC_PAIR_W-1:0];
         chan_reg <= SAC_CHAN_RST[SAC_CHAN_W-1:0];
         div_reg  <= SAC_CFG_RST[SAC_DIV_LSB +: SAC_DIV_W];
         gain_reg <= SAC_CFG_RST[SAC_GAIN_LSB +: 2];
      end else begin
         if (wr_pair) begin
            pair_reg <= SFR_WDATA_I[SAC_PAIR_W-1:0];  // [RULE19]
         end
         if (wr_chan) begin
            chan_reg <= SFR_WDATA_I[SAC_CHAN_W-1:0];  // [RULE19]
         end
         if (wr_cfg) begin
            div_reg  <= SFR_WDATA_I[SAC_DIV_LSB +: SAC_DIV_W];
            gain_reg <= SFR_WDATA_I[SAC_GAIN_LSB +: 2];
         end
      end
   end

   // control fields written directly by software
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         en_reg   <= SAC_CTRL_RST[SAC_EN_BIT];
         lp_reg   <= SAC_CTRL_RST[SAC_LP_BIT];
         mode_reg <= SAC_CTRL_RST[SAC_MODE_LSB +: SAC_MODE_W];
      end else if (wr_ctrl) begin
         en_reg   <= SFR_WDATA_I[SAC_EN_BIT];
         lp_reg   <= SFR_WDATA_I[SAC_LP_BIT];
         mode_reg <= SFR_WDATA_I[SAC_MODE_LSB +: SAC_MODE_W];
      end
   end

   // sticky flags: hardware set beats a software write in the same cycle
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         done_reg <= SAC_CTRL_RST[SAC_DONE_BIT];
         win_reg  <= SAC_CTRL_RST[SAC_WIN_BIT];
      end else begin
         if (conv_end) begin
            done_reg <= 1'b1;  // [RULE3]
         end else if (wr_ctrl) begin
            done_reg <= SFR_WDATA_I[SAC_DONE_BIT];  // [RULE4]
         end
         if (conv_end && res.match) begin
            win_reg <= 1'b1;  // [RULE13]
         end else if (wr_ctrl) begin
            win_reg <= SFR_WDATA_I[SAC_WIN_BIT];
         end
      end
   end

   // two-flop synchronisers for the external start pins
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         own_s1 <= 1'b0;
         own_s2 <= 1'b0;
         sh_s1  <= 1'b0;
         sh_s2  <= 1'b0;
      end else begin
         own_s1 <= EXT_START_OWN_I;
         own_s2 <= own_s1;
         sh_s1  <= EXT_START_SHARED_I;
         sh_s2  <= sh_s1;
      end
   end

   // own pin first; shared pin only when own is not routed out
   assign ext_level = OWN_PIN_EN_I ? own_s2
                                   : (SHARED_PIN_EN_I && sh_s2);  // [RULE12]

   // previous level for the rising-edge detector
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ext_prev_reg <= 1'b0;
      end else begin
         ext_prev_reg <= ext_level;
      end
   end

   assign ext_rise = ext_level && !ext_prev_reg;

   // start sources; the stored mode decides, not the byte being written
   assign sw_go  = wr_ctrl && SFR_WDATA_I[SAC_BUSY_BIT]
                && (mode_reg == SAC_MODE_SW);                   // [RULE6]
   assign int_go = sw_go
                || ((mode_reg == SAC_MODE_T3) && T3_OVF_I)      // [RULE7]
                || ((mode_reg == SAC_MODE_T2) && T2_OVF_I)      // [RULE7]
                || (mode_reg[2] && COMPANION_BUSY_WR_I);        // [RULE9]
   assign ext_go = (mode_reg == SAC_MODE_EXT) && ext_rise;     // [RULE8]

   assign busy     = (state_reg != S_IDLE);  // [RULE5]
   assign conv_end = en_reg && (state_reg == S_CONV) && sar_tick
                  && (cnt_reg == CONV_LAST);

   // conversion clock source, running only while a conversion is open
   sac_sar_clkdiv u_div (
      .clk_i     (CLOCK_I),
      .rst_n_i   (RST_N_I),
      .run_i     (busy),
      .div_i     (div_reg),          // [RULE14]
      .tick_o    (sar_tick),
      .sar_clk_o (SAR_CLK_O)
   );

   // sequencer next state; triggers are only looked at in idle
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         S_IDLE: begin
            if (!en_reg) begin
               state_next = S_IDLE;  // [RULE1]
            end else if (ext_go) begin
               state_next = S_CONV;  // [RULE8] [RULE11]
            end else if (int_go) begin
               state_next = lp_reg ? S_TRACK : S_CONV;  // [RULE10]
            end
         end
         S_TRACK: begin
            if (!en_reg) begin
               state_next = S_IDLE;  // [RULE1]
            end else if (sar_tick && cnt_reg == TRK_LAST) begin
               state_next = S_CONV;  // [RULE10]
            end
         end
         S_CONV: begin
            if (!en_reg || conv_end) begin
               state_next = S_IDLE;
            end else begin
               state_next = S_CONV;  // [RULE22]
            end
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_reg <= S_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // counts conversion clocks; clears on every state change
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         cnt_reg <= 4'h0;
      end else if (state_next != state_reg) begin
         cnt_reg <= 4'h0;
      end else if (sar_tick) begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end

   // analog control lines, registered from the next state; the active line from the enable
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         TRACK_O       <= 1'b0;
         CONVERT_O     <= 1'b0;
         CONV_ACTIVE_O <= 1'b0;
      end else begin
         CONV_ACTIVE_O <= en_reg;  // [RULE1]
         CONVERT_O     <= (state_next == S_CONV);
         if (!lp_reg) begin
            TRACK_O <= en_reg && (state_next != S_CONV);  // [RULE2]
         end else begin
            // low-power: fixed track window, or pin low in external mode
            TRACK_O <= en_reg && ((state_next == S_TRACK)
                    || ((state_next == S_IDLE)
                    && (mode_reg == SAC_MODE_EXT)
                    && !ext_level));  // [RULE10] [RULE11]
         end
      end
   end

   // mux and gain settings follow the registers one cycle later
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         MUX_POS_O  <= 3'h0;
         MUX_NEG_O  <= 3'h0;
         MUX_DIFF_O <= 1'b0;
         AMP_GAIN_O <= 2'h0;
      end else begin
         MUX_POS_O  <= chan_reg;                          // [RULE17]
         MUX_NEG_O  <= sac_neg(pair_reg, chan_reg);       // [RULE17]
         MUX_DIFF_O <= sac_is_diff(pair_reg, chan_reg);   // [RULE16]
         AMP_GAIN_O <= gain_reg;                          // [RULE15]
      end
   end

   // end-of-conversion event for the interrupt controller
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         CONV_IRQ_O <= 1'b0;
      end else begin
         CONV_IRQ_O <= conv_end;  // [RULE20]
      end
   end

   // read data registered; unused bits and unmapped addresses give zero
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         SFR_RDATA_O <= 8'h00;
      end else if (SFR_RD_I) begin
         case (SFR_ADDR_I)
            SAC_ADDR_PAIR: SFR_RDATA_O <= {4'h0, pair_reg};  // [RULE19]
            SAC_ADDR_CHAN: SFR_RDATA_O <= {5'h00, chan_reg}; // [RULE19]
            SAC_ADDR_CFG:  SFR_RDATA_O <= {div_reg, 1'b0, gain_reg};
            SAC_ADDR_CTRL: SFR_RDATA_O <= {en_reg, lp_reg, done_reg, busy,
                                           mode_reg, win_reg};  // [RULE5]
            default:       SFR_RDATA_O <= 8'h00;
         endcase
      end
   end

   // result path hookup
   assign res.raw  = CORE_RESULT_I;
   assign res.diff = sac_is_diff(pair_reg, chan_reg);  // [RULE18]
   assign res.load = conv_end;                         // [RULE20]
   assign res.gt   = GT_LIMIT_I;
   assign res.lt   = LT_LIMIT_I;

   sac_window u_win (
      .clk_i   (CLOCK_I),
      .rst_n_i (RST_N_I),
      .res     (res)
   );

   assign DATA_WORD_O = res.word;

   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);

   a_done_on_fall: assert property ($fell(busy) && $past(en_reg)
      |-> done_reg && CONV_IRQ_O ##1 !CONV_IRQ_O)
      else $error("done flag or event missing at busy fall"); // [RULE3]
   a_disable_stops: assert property (!en_reg |=> !busy ##1 !CONVERT_O)
      else $error("conversion runs while disabled"); // [RULE1]
   a_sw_start: assert property (sw_go && en_reg && !busy && !lp_reg
      && !ext_go |=> state_reg == S_CONV ##1 CONVERT_O)
      else $error("software start did not convert"); // [RULE6]
   a_sw_wrong_mode: assert property (wr_ctrl && SFR_WDATA_I[SAC_BUSY_BIT]
      && mode_reg != SAC_MODE_SW && !int_go && !ext_go && !busy |=> !busy)
      else $error("busy write started outside software mode"); // [RULE6]
   a_timer_start: assert property (en_reg && !busy && !lp_reg && !ext_go
      && mode_reg == SAC_MODE_T2 && T2_OVF_I |=> state_reg == S_CONV)
      else $error("timer overflow did not start"); // [RULE7]
   a_ext_start: assert property (en_reg && !busy && ext_go
      |=> state_reg == S_CONV)
      else $error("external edge did not start"); // [RULE8]
   a_lp_track_len: assert property (state_reg == S_TRACK && en_reg
      && sar_tick && cnt_reg == TRK_LAST |=> state_reg == S_CONV)
      else $error("low-power track not three clocks"); // [RULE10]
   a_busy_ignore: assert property (en_reg && state_reg == S_CONV
      && !sar_tick |=> state_reg == S_CONV)
      else $error("conversion disturbed"); // [RULE22]
   a_norm_no_track: assert property (en_reg && !lp_reg && !busy
      && !ext_go && !int_go |=> TRACK_O)
      else $error("normal mode not tracking when idle"); // [RULE2]
   a_unused_zero: assert property (SFR_RD_I && SFR_ADDR_I == SAC_ADDR_CHAN
      |=> SFR_RDATA_O[7:3] == 5'h00)
      else $error("unused bits not zero"); // [RULE19]
   a_window_set: assert property (conv_end && res.match |=> win_reg)
      else $error("window flag not set"); // [RULE13]

   c_sw_done: cover property (sw_go ##[1:300] conv_end);
   c_lp_track: cover property (state_reg == S_TRACK ##1 state_reg == S_CONV);
   c_ext_conv: cover property (ext_go && !busy && en_reg ##[1:300] conv_end);
   c_win_hit: cover property (conv_end && res.match);
endmodule
`default_nettype wire

/* File: sim/sac_core_model.sv */
// partner: analog core model returning a code only while converting
`timescale 1ns/1ps
`default_nettype none
module sac_core_model (
   // clock and core handshake
   input  wire logic       clk_i,
   input  wire logic       convert_i,
   input  wire logic [7:0] code_i,
   output logic      [7:0] result_o
);
   // start from a known but meaningless code
   initial result_o = 8'h5A;
   // code held only while converting; otherwise it is negated every clock
   always @(posedge clk_i) begin
      if (convert_i) begin
         result_o <= code_i;
      end else begin
         result_o <= ~result_o + 8'h01;
      end
   end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// testbench: registers, start sources, timing and mux of the control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sac_pkg::*;
   localparam int CONV = 4;               // shortened conversion length
   // stimulus and observed signals
   logic       clk, rst_n, wr_s, rd_s, oe, se, act, trk, cnv, sck, dif, irq;
   logic [7:0] addr, wd, gt, lt, code, res, rdat, word;
   logic [4:0] src;                       // t3, t2, companion, own, shared
   logic [2:0] pos, neg;
   logic [1:0] gain;
   logic       rd1, rd2;                  // read pipeline of the monitor
   int         n_mismatch, n_compared;
   int         bitof [6] = '{0, 0, 3, 1, 2, 4};  // trigger kind to source
   logic [7:0] q_rd [$], q_wd [$];        // expected read data, data words
   sac_top #(.CONV_CLKS(CONV)) sac_top_inst (
      .CLOCK_I(clk), .RST_N_I(rst_n), .SFR_ADDR_I(addr), .SFR_WDATA_I(wd),
      .SFR_WR_I(wr_s), .SFR_RD_I(rd_s), .SFR_RDATA_O(rdat),
      .T3_OVF_I(src[0]), .T2_OVF_I(src[1]), .COMPANION_BUSY_WR_I(src[2]),
      .EXT_START_OWN_I(src[3]), .EXT_START_SHARED_I(src[4]),
      .OWN_PIN_EN_I(oe), .SHARED_PIN_EN_I(se), .GT_LIMIT_I(gt),
      .LT_LIMIT_I(lt), .CORE_RESULT_I(res), .CONV_ACTIVE_O(act),
      .TRACK_O(trk), .CONVERT_O(cnv), .SAR_CLK_O(sck), .AMP_GAIN_O(gain),
      .MUX_POS_O(pos), .MUX_NEG_O(neg), .MUX_DIFF_O(dif),
      .DATA_WORD_O(word), .CONV_IRQ_O(irq));
   sac_core_model sac_core_model_inst (.clk_i(clk), .convert_i(cnv),
      .code_i(code), .result_o(res));
   // 20 MHz system clock
   always #25 clk = ~clk;
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_compared++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // leftover notes count as misses too
   task automatic end_sim;
      n_mismatch += q_rd.size() + q_wd.size();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // monitor: read data one edge after the taking edge, word at the event
   always @(posedge clk) begin
      rd1 <= rd_s;
      rd2 <= rd1;
   end
   always @(negedge clk) begin
      if (rd2 === 1'b1) chk(rdat, q_rd.size() ? q_rd.pop_front() : 8'hXX);
      if (irq === 1'b1)
         chk(word, q_wd.size() ? q_wd.pop_front() : 8'hXX);
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      q_rd.push_back(e);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
   endtask
   // one trigger: 0 busy write, 1 t3, 2 own pin, 3 t2, 4 companion, 5 shared
   task automatic fire(input int k, input logic [2:0] mv);
      oe <= (k != 5);
      if (k == 0) wr(SAC_ADDR_CTRL, {4'h9, mv, 1'b0});
      else begin
         @(posedge clk);
         src[bitof[k]] <= 1'b1;
         repeat ((k == 2 || k == 5) ? 4 : 1) @(posedge clk);
         src <= 5'h00;
      end
   endtask
   // software start, busy read mid-run, then control readback
   task automatic conv(input logic [7:0] c, input logic [7:0] w,
                       input logic [7:0] r);
      code <= c;
      q_wd.push_back(w);
      wr(SAC_ADDR_CTRL, 8'h90);
      rd(SAC_ADDR_CTRL, 8'h90);
      repeat (20) @(posedge clk);
      rd(SAC_ADDR_CTRL, r);
   endtask
   // cycles from the start write to the completion event
   // also counts track, convert and conversion clock cycles, divider 1
   task automatic timed(input logic [7:0] ctl, input int exp);
      int n, nt, nc, ns;
      logic [7:0] c;
      c = 8'($urandom);
      code <= c;
      q_wd.push_back(c);
      wr(SAC_ADDR_CTRL, ctl);
      n = 0;
      nt = 0;
      nc = 0;
      ns = 0;
      do begin
         @(negedge clk);
         n++;
         nt += trk;
         nc += cnv;
         ns += sck;
      end while (irq !== 1'b1 && n < 100);
      chk(8'(n), 8'(exp));
      chk(8'(nt), ctl[6] ? 8'h06 : 8'h01);
      chk(8'(nc), 8'(CONV * 2));
      chk(8'(ns), 8'(CONV + (ctl[6] ? 3 : 0)));
   endtask
   // hang guard, well beyond the expected run
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      end_sim();
   end
   initial begin
      logic [2:0] mv;
      logic [7:0] c, pr;
      logic       hit;
      void'($urandom(32'h51C20366));
      {clk, rst_n, wr_s, rd_s, oe, se, src} = 11'h060;
      {addr, wd, code} = 24'h0;
      gt = 8'hFF;
      lt = 8'h00;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd(SAC_ADDR_PAIR, 8'h00);
      rd(SAC_ADDR_CFG, 8'hF8);
      rd(SAC_ADDR_CTRL, 8'h00);
      rd(8'h00, 8'h00);
      wr(SAC_ADDR_PAIR, 8'hFF);
      rd(SAC_ADDR_PAIR, 8'h0F);
      wr(SAC_ADDR_CHAN, 8'hFF);
      rd(SAC_ADDR_CHAN, 8'h07);
      wr(SAC_ADDR_CFG, 8'hFF);
      rd(SAC_ADDR_CFG, 8'hFB);
      // gain codes; the last write leaves divider 1
      for (int g = 0; g < 4; g++) begin
         wr(SAC_ADDR_CFG, 8'h08 | 8'(g));
         repeat (2) @(negedge clk);
         chk({6'h0, gain}, 8'(g));
      end
      // pin pairing and polarity for every channel code
      pr = 8'($urandom);
      wr(SAC_ADDR_PAIR, pr);
      for (int ch = 0; ch < 8; ch++) begin
         wr(SAC_ADDR_CHAN, 8'(ch));
         repeat (2) @(negedge clk);
         hit = pr[ch >> 1];
         chk({dif, 1'b0, neg, pos},
             {hit, 1'b0, hit ? 3'(ch ^ 1) : 3'h0, 3'(ch)});
      end
      // disabled: a start write is ignored and nothing is stored
      wr(SAC_ADDR_CTRL, 8'h10);
      repeat (20) @(posedge clk);
      rd(SAC_ADDR_CTRL, 8'h00);
      wr(SAC_ADDR_CTRL, 8'h80);
      repeat (2) @(negedge clk);
      chk({7'h0, act}, 8'h01);
      // differential word, then a window hit on a single-ended input
      wr(SAC_ADDR_PAIR, 8'h0F);
      wr(SAC_ADDR_CHAN, 8'h00);
      c = 8'($urandom);
      conv(c, c ^ 8'h80, 8'hA0);
      wr(SAC_ADDR_PAIR, 8'h00);
      gt <= 8'h10;
      lt <= 8'h20;
      conv(8'h18, 8'h18, 8'hA1);
      gt <= 8'hFF;
      lt <= 8'h00;
      // event comes at the edge where busy falls, seen one negedge later
      timed(8'h90, CONV * 2 + 1);
      wr(SAC_ADDR_CTRL, 8'hC0);
      timed(8'hD0, CONV * 2 + 1 + 6);
      // low-power external mode tracks while the pin sits low
      wr(SAC_ADDR_CTRL, 8'hC4);
      repeat (2) @(negedge clk);
      chk({7'h0, trk}, 8'h01);
      // every start mode against every trigger kind
      for (int m = 0; m < 5; m++) begin
         for (int k = 0; k < 6; k++) begin
            mv = (m < 4) ? 3'(m) : 3'(4 + $urandom % 4);
            hit = (m == k) || (m == 2 && k == 5);
            c = 8'($urandom);
            code <= c;
            if (hit) q_wd.push_back(c);
            wr(SAC_ADDR_CTRL, {4'h8, mv, 1'b0});
            fire(k, mv);
            repeat (30) @(posedge clk);
            rd(SAC_ADDR_CTRL, {2'b10, hit, 1'b0, mv, 1'b0});
         end
      end
      repeat (4) @(posedge clk);
      end_sim();
   end
endmodule
`default_nettype wire
